// *** tb/smug_host_model.sv ***
// host application model: flow-controlled sender and rts driver
`default_nettype none
module smug_host_model (
    // clock
    input  wire logic       clock_in,
    // from the device and the bench
    input  wire logic [1:0] cts_n_in,
    input  wire logic       send_in,
    input  wire logic [1:0] rts_n_set_in,
    // towards the device
    output logic [1:0]      rts_n_out,
    output logic [1:0]      rx_start_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend = 1'b0;
    initial rts_n_out = 2'b11;
    initial rx_start_out = 2'b00;
    // a character waits until cts opens, never sent into a closed port
    always @(posedge clock_in) begin
        rts_n_out <= rts_n_set_in;
        rx_start_out <= 2'b00;
        if ((send_in || pend) && cts_n_in == 2'b00) begin
            pend <= 1'b0;
            rx_start_out <= 2'b01;
        end else if (send_in) begin
            pend <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** tb/smug_top_properties.sv ***
// bound checker for the sleep-mode serial gating sequencer ports
`default_nettype none
module smug_top_properties (
    // clock and reset
    input wire logic                 clock_in,
    input wire logic                 rst_n_in,
    // commands, pins and events
    input wire logic                 cmd_valid_in,
    input wire logic [1:0]           rts_n_in,
    input wire smug_pkg::smug_wake_t wake_in,
    input wire logic                 packet_active_in,
    // gating outputs
    input wire logic [1:0]           cts_n_out,
    input wire logic                 uart_en_out,
    input wire logic [1:0]           host_ready_out,
    input wire logic                 power_save_out,
    input wire logic [3:0]           level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    logic cmd_d;
    logic quiet;
    // a command in the last two cycles may still be moving level_out
    always_ff @(posedge clock_in) begin
        cmd_d <= cmd_valid_in;
    end
    assign quiet = !cmd_valid_in && !cmd_d;
    sequence s_full_back;
        ##2 level_out == 4'h1 && uart_en_out && cts_n_out == 2'b00;
    endsequence
    property p_reset;
        $rose(rst_n_in) |-> level_out == 4'h1 && uart_en_out && cts_n_out == 2'b00 && !power_save_out;
    endproperty
    property p_cts_pair;
        cts_n_out[0] == cts_n_out[1];
    endproperty
    property p_l0_closed;
        level_out == 4'h0 |-> !uart_en_out && cts_n_out == 2'b11 && host_ready_out == 2'b00;
    endproperty
    property p_sleep;
        power_save_out |-> cts_n_out == 2'b11 && !uart_en_out;
    endproperty
    property p_packet;
        packet_active_in |=> !power_save_out;
    endproperty
    property p_ready;
        (host_ready_out & $past(rts_n_in)) == 2'b00;
    endproperty
    property p_wake_std;
        (level_out == 4'h0 || level_out == 4'h5 || level_out == 4'h6) && (|wake_in[3:1]) && quiet
            |-> s_full_back;
    endproperty
    property p_keep_78;
        (level_out == 4'h7 || level_out == 4'h8) && quiet |=> $stable(level_out);
    endproperty
    property p_rts_wake;
        level_out == 4'h0 && quiet && ($fell(rts_n_in[0]) || $fell(rts_n_in[1])) |-> ##[2:3] level_out == 4'h1;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not at reset values");
    a_cts_pair: assert property (p_cts_pair) else $error("cts differs between ports");
    a_l0_closed: assert property (p_l0_closed) else $error("serial port open in level 0");
    a_sleep: assert property (p_sleep) else $error("power saving with port open");
    a_packet: assert property (p_packet) else $error("power saving during packet data");
    a_ready: assert property (p_ready) else $error("host ready without rts");
    a_wake_std: assert property (p_wake_std) else $error("wake event did not restore level 1");
    a_keep_78: assert property (p_keep_78) else $error("level 7 or 8 left without command");
    a_rts_wake: assert property (p_rts_wake) else $error("rts edge did not wake level 0");
endmodule
bind smug_top smug_top_properties props (.*);
`default_nettype wire

// *** tb/smug_top_tb_top.sv ***
// self-checking bench for the sleep-mode serial gating sequencer
`default_nettype none
module smug_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] FR = 20'h14;
    localparam logic [19:0] WN = 20'h4;
    localparam logic [19:0] MS = 20'h4;
    localparam logic [19:0] HS = 20'h3;
    localparam logic [19:0] HL = 20'h6;
    logic clock_in = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0, rd_en = 1'b0, cmd_valid = 1'b0, send = 1'b0, packet = 1'b0, xfer_end = 1'b0;
    logic [3:0] cmd_level = 4'h1;
    logic char_done = 1'b0;
    logic [1:0] rts_set = 2'h3, tx_pend = 2'h0;
    smug_pkg::smug_wake_t wake = '0;
    logic [1:0] rts_n, rx_start, cts_n, host_ready;
    logic [31:0] rd_data;
    logic uart_en, power_save;
    logic [3:0] level;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    always #12.5 clock_in = ~clock_in;
    smug_top #(.FRAME_CYC(FR), .WIN_CYC(WN), .MS_CYC(MS), .HOLD_SHORT_MS(HS), .HOLD_LONG_MS(HL)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wr_data), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rd_data_out(rd_data), .cmd_valid_in(cmd_valid), .cmd_level_in(cmd_level),
        .rts_n_in(rts_n), .rx_start_in(rx_start), .tx_pending_in(tx_pend), .char_done_in(char_done),
        .wake_in(wake), .packet_active_in(packet), .transfer_end_in(xfer_end), .cts_n_out(cts_n),
        .uart_en_out(uart_en), .host_ready_out(host_ready), .power_save_out(power_save), .level_out(level));
    smug_host_model host (.clock_in(clock_in), .cts_n_in(cts_n), .send_in(send), .rts_n_set_in(rts_set),
        .rts_n_out(rts_n), .rx_start_out(rx_start));
    task automatic report_and_stop;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock_in);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clock_in);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock_in);
        rd_en <= 1'b0;
        @(negedge clock_in);
        check(rd_data, exp);
    endtask
    // ends on a falling edge, with level_out already showing the result
    task automatic cmd(input logic [3:0] l);
        @(posedge clock_in);
        cmd_valid <= 1'b1;
        cmd_level <= l;
        @(posedge clock_in);
        cmd_valid <= 1'b0;
        @(posedge clock_in);
        @(negedge clock_in);
    endtask
    task automatic wait_cts(input logic [1:0] v, input int lim, output int n);
        n = 0;
        while (cts_n !== v && n < lim) begin
            @(negedge clock_in);
            n++;
        end
    endtask
    task automatic t_regs;
        rd(smug_pkg::OFS_STATUS, 32'ha1);
        rd(smug_pkg::OFS_LEVEL, 32'h1);
        rd(smug_pkg::OFS_DRX, 32'h2);
        wr(smug_pkg::OFS_DRX, 32'ha);
        rd(smug_pkg::OFS_DRX, 32'h2);
        wr(smug_pkg::OFS_DRX, 32'h1);
        rd(smug_pkg::OFS_DRX, 32'h2);
        wr(smug_pkg::OFS_DRX, 32'h9);
        rd(smug_pkg::OFS_DRX, 32'h9);
        wr(smug_pkg::OFS_DRX, 32'h3);
        rd(5'h14, 32'h0);
        cmd(4'h5);
        check(32'(level), 32'h1);
        wr(smug_pkg::OFS_FLOW, 32'h3);
        rd(smug_pkg::OFS_FLOW, 32'h3);
    endtask
    task automatic t_level0;
        cmd(4'h0);
        check(32'(uart_en), 32'h0);
        repeat (3100) @(negedge clock_in);
        check(32'(cts_n), 32'h3);
        check(32'(power_save), 32'h1);
        @(posedge clock_in) rts_set <= 2'b10;
        repeat (5) @(negedge clock_in);
        check(32'(level), 32'h1);
        @(posedge clock_in) rts_set <= 2'b11;
    endtask
    task automatic t_wake(input logic [3:0] l, input smug_pkg::smug_wake_t w, input logic [3:0] exp);
        cmd(l);
        @(posedge clock_in) wake <= w;
        @(posedge clock_in) wake <= '0;
        repeat (3) @(negedge clock_in);
        check(32'(level), 32'(exp));
        if (level !== 4'h1) begin
            cmd(4'h1);
            check(32'(level), 32'h1);
        end
    endtask
    // transfer end closes 7 and 8 at once; 5 and 6 run their hold time
    task automatic t_hold(input logic [3:0] l, input int lo, input int hi);
        int n;
        cmd(l);
        @(posedge clock_in) xfer_end <= 1'b1;
        @(posedge clock_in) xfer_end <= 1'b0;
        @(negedge clock_in);
        wait_cts(2'b11, 100, n);
        check(32'(n >= lo && n <= hi), 32'h1);
        cmd(4'h1);
        check(32'(level), 32'(l));
        @(posedge clock_in) tx_pend <= 2'b10;
        @(negedge clock_in);
        wait_cts(2'b00, 4, n);
        check(32'(cts_n), 32'h0);
        cmd(4'h1);
        check(32'(level), 32'h1);
        @(posedge clock_in) tx_pend <= 2'b00;
    endtask
    task automatic t_page;
        int n;
        int t0;
        cmd(4'h5);
        @(posedge clock_in) rts_set <= 2'b00;
        @(posedge clock_in) packet <= 1'b1;
        @(negedge clock_in);
        wait_cts(2'b11, 40, n);
        wait_cts(2'b00, 3200, n);
        t0 = cycles;
        wait_cts(2'b11, 20, n);
        check(n, WN);
        check(32'(uart_en), 32'h1);
        repeat (WN + 2) @(negedge clock_in);
        check(32'(uart_en), 32'h0);
        check(32'(power_save), 32'h0);
        @(posedge clock_in) packet <= 1'b0;
        repeat (3) @(negedge clock_in);
        check(32'(power_save), 32'h1);
        wait_cts(2'b00, 3200, n);
        check(cycles - t0, 153 * FR);
        check(32'(level), 32'h5);
        @(posedge clock_in) send <= 1'b1;
        @(posedge clock_in) send <= 1'b0;
        repeat (3) @(negedge clock_in);
        check(32'(host_ready), 32'h3);
        // a finished character restarts the hold time
        @(posedge clock_in) char_done <= 1'b1;
        @(posedge clock_in) char_done <= 1'b0;
        @(negedge clock_in);
        wait_cts(2'b11, 100, n);
        check(n, HS * MS + 2);
        @(posedge clock_in) tx_pend <= 2'b01;
        cmd(4'h1);
        check(32'(level), 32'h1);
        @(posedge clock_in) tx_pend <= 2'b00;
        rts_set <= 2'b11;
    endtask
    initial begin
        repeat (10) @(posedge clock_in);
        rst_n <= 1'b1;
        @(negedge clock_in);
        t_regs;
        t_level0;
        t_wake(4'h0, 4'h2, 4'h1);
        t_wake(4'h5, 4'h4, 4'h1);
        t_wake(4'h6, 4'h8, 4'h1);
        t_wake(4'h7, 4'h2, 4'h7);
        t_wake(4'h8, 4'h8, 4'h8);
        t_wake(4'h6, 4'h1, 4'h6);
        wr(smug_pkg::OFS_SMSIND, 32'h1);
        t_wake(4'h5, 4'h1, 4'h1);
        t_wake(4'h8, 4'h1, 4'h8);
        t_hold(4'h5, HS * MS - 6, HS * MS + MS + 2);
        t_hold(4'h6, HL * MS - 6, HL * MS + MS + 2);
        t_hold(4'h7, 0, 3);
        t_hold(4'h8, 0, 3);
        t_page;
        report_and_stop;
    end
endmodule
`default_nettype wire

// *** verilog/smug_pkg.sv ***
// constants and types for the sleep-mode serial gating sequencer
// Functional notes
// R1: level 0 keeps serial interface blocked
// R2: level 0 wakes briefly per page, stays closed
// R3: first wake event in level 0 restores level 1
// R4: levels 5-8 cyclic; packet data keeps level
// R5: levels 7,8 resume sleep after sms/call end
// R6: cyclic: cts low while uart active, else high; code keeps cts high with uart open in the second half of the window
// R7: cyclic sleep needs rts/cts hardware flow control
// R8: both serial ports share level and cts
// R9: cts goes low at each paging block start
// R10: paging interval is frame times 51 times drx
// R11: drx accepted only from 2 to 9
// R12: cts low 4.6 ms, uart open 4.6 ms more
// R13: start bit inside 9.2 ms window opens cts
// R14: pending transmit character opens cts anytime
// R15: hold 2 s (5,7) or 10 min (6,8)
// R16: cts high: power saving, no commands accepted; code accepts commands, without power saving, in the second half of the window
// R17: rts wakes only in level 0, falling edge
// R18: result, call, alarm wake from 0,5,6 only
// R19: commands and packet data never end cyclic sleep
// R20: sms wakes 0,5,6 only with indication enabled
// R21: level 1 command ends any cyclic sleep
// R22: host should arm rtc alarm before level 0
// R23: level 1 after reset
// R24: window or hold expiry closes cts, sleeps
`default_nettype none
package smug_pkg;
    // clock and times
    localparam longint CLK_PERIOD_NS  = 25;
    localparam longint FRAME_NS       = 4615000;
    localparam longint CTS_LOW_US     = 4600;
    localparam longint MS_NS          = 1000000;
    localparam longint HOLD_SHORT_S   = 2;
    localparam longint HOLD_LONG_MIN  = 10;
    localparam logic [19:0] FRAME_CYC = 20'((FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [19:0] WIN_CYC   = 20'((CTS_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [19:0] MS_CYC    = 20'(MS_NS / CLK_PERIOD_NS);
    localparam logic [19:0] HOLD_SHORT_MS = 20'(HOLD_SHORT_S * 1000);
    localparam logic [19:0] HOLD_LONG_MS  = 20'(HOLD_LONG_MIN * 60 * 1000);
    localparam logic [5:0]  FRAMES_PER_BLOCK = 6'h33;
    // drx limits and reset values
    localparam logic [3:0] DRX_MIN   = 4'h2;
    localparam logic [3:0] DRX_MAX   = 4'h9;
    localparam logic [3:0] DRX_RESET = 4'h2;
    localparam logic [1:0] FLOW_NONE = 2'h0;
    localparam logic [1:0] FLOW_HW   = 2'h3;
    // functionality levels
    localparam logic [3:0] LVL_NONCYC = 4'h0;
    localparam logic [3:0] LVL_FULL   = 4'h1;
    localparam logic [3:0] LVL_C5     = 4'h5;
    localparam logic [3:0] LVL_C6     = 4'h6;
    localparam logic [3:0] LVL_C7     = 4'h7;
    localparam logic [3:0] LVL_C8     = 4'h8;
    // register byte offsets
    localparam logic [4:0] OFS_LEVEL  = 5'h00;
    localparam logic [4:0] OFS_DRX    = 5'h04;
    localparam logic [4:0] OFS_FLOW   = 5'h08;
    localparam logic [4:0] OFS_SMSIND = 5'h0c;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    typedef enum logic [5:0] {
        ST_FULL       = 6'h01,
        ST_NCS        = 6'h02,
        ST_NCS_LISTEN = 6'h04,
        ST_CS_SLEEP   = 6'h08,
        ST_CS_WIN     = 6'h10,
        ST_CS_ACTIVE  = 6'h20
    } smug_state_t;
    typedef struct packed {
        logic unsolicited_result;
        logic incoming_call;
        logic rtc_alarm;
        logic incoming_sms;
    } smug_wake_t;
    typedef struct packed {
        logic [5:0] state;
        logic       power_save;
        logic       uart_en;
        logic       cts_n;
        logic [3:0] level;
    } smug_status_t;
endpackage
`default_nettype wire

// *** verilog/smug_top.sv ***
// sleep level sequencer and serial port gating for both serial ports
`default_nettype none
module smug_top #(
    parameter logic [19:0] FRAME_CYC     = smug_pkg::FRAME_CYC,
    parameter logic [19:0] WIN_CYC       = smug_pkg::WIN_CYC,
    parameter logic [19:0] MS_CYC        = smug_pkg::MS_CYC,
    parameter logic [19:0] HOLD_SHORT_MS = smug_pkg::HOLD_SHORT_MS,
    parameter logic [19:0] HOLD_LONG_MS  = smug_pkg::HOLD_LONG_MS
) (
    // clock and reset
    input  wire logic               clock_in,
    input  wire logic               rst_n_in,
    // register port
    input  wire logic [4:0]         addr_in,
    input  wire logic [31:0]        wr_data_in,
    input  wire logic               wr_en_in,
    input  wire logic               rd_en_in,
    output logic [31:0]             rd_data_out,
    // level command from the host parser
    input  wire logic               cmd_valid_in,
    input  wire logic [3:0]         cmd_level_in,
    // serial port activity, index 0 first port, 1 second port
    input  wire logic [1:0]         rts_n_in,
    input  wire logic [1:0]         rx_start_in,
    input  wire logic [1:0]         tx_pending_in,
    input  wire logic               char_done_in,
    // modem events
    input  wire smug_pkg::smug_wake_t wake_in,
    input  wire logic               packet_active_in,
    input  wire logic               transfer_end_in,
    // gating outputs
    output logic [1:0]              cts_n_out,
    output logic                    uart_en_out,
    output logic [1:0]              host_ready_out,
    output logic                    power_save_out,
    output logic [3:0]              level_out
);
    smug_pkg::smug_state_t state_reg;
    smug_pkg::smug_state_t state_next;
    logic [3:0]  level_reg;
    logic [3:0]  level_next;
    logic [3:0]  drx_reg;
    logic [1:0]  flow_reg;
    logic        sms_ind_reg;
    logic [1:0]  rts_n_reg;
    logic [19:0] frame_cyc_reg;
    logic [8:0]  frame_num_reg;
    logic [19:0] tmr_reg;
    logic [19:0] ms_div_reg;
    logic [19:0] hold_ms_reg;
    logic [8:0]  frames_per_page;
    logic        page_start;
    logic        rts_fall;
    logic        rx_start;
    logic        tx_pend;
    logic        wake_any;
    logic        wake_lvl0;
    logic        wake_cyc;
    logic        uart_open;
    logic        cmd_ok;
    logic        activity;
    logic        hold_restart;
    logic        hold_done;
    logic [19:0] hold_limit;
    logic        cts_low;
    smug_pkg::smug_status_t status;

    function automatic logic is_cyclic(input logic [3:0] lvl);
        is_cyclic = (lvl == smug_pkg::LVL_C5) || (lvl == smug_pkg::LVL_C6) ||
                    (lvl == smug_pkg::LVL_C7) || (lvl == smug_pkg::LVL_C8);
    endfunction

    function automatic logic is_valid(input logic [3:0] lvl);
        is_valid = is_cyclic(lvl) || (lvl == smug_pkg::LVL_NONCYC) || (lvl == smug_pkg::LVL_FULL);
    endfunction

    function automatic smug_pkg::smug_state_t state_for(input logic [3:0] lvl);
        if (lvl == smug_pkg::LVL_NONCYC) begin
            state_for = smug_pkg::ST_NCS;
        end else if (is_cyclic(lvl)) begin
            // hold window runs first so the answer to the command gets out
            state_for = smug_pkg::ST_CS_ACTIVE;
        end else begin
            state_for = smug_pkg::ST_FULL;
        end
    endfunction

    // both ports are merged: one level and one cts schedule
    assign rx_start = |rx_start_in; // R8
    assign tx_pend  = |tx_pending_in; // R8
    assign rts_fall = |(rts_n_reg & ~rts_n_in); // R17
    assign wake_any = wake_in.unsolicited_result | wake_in.incoming_call | wake_in.rtc_alarm |
                      (wake_in.incoming_sms & sms_ind_reg); // R20
    assign wake_lvl0 = wake_any | rts_fall; // R3 R17
    assign wake_cyc  = wake_any & ((level_reg == smug_pkg::LVL_C5) || (level_reg == smug_pkg::LVL_C6)); // R18
    assign uart_open = (state_reg == smug_pkg::ST_FULL) || (state_reg == smug_pkg::ST_CS_WIN) ||
                       (state_reg == smug_pkg::ST_CS_ACTIVE); // R16
    // cyclic levels refused until hardware handshake is selected
    assign cmd_ok = cmd_valid_in && uart_open && is_valid(cmd_level_in) &&
                    (!is_cyclic(cmd_level_in) || (flow_reg == smug_pkg::FLOW_HW)); // R7
    assign activity = rx_start | char_done_in | tx_pend | cmd_valid_in;
    assign hold_limit = ((level_reg == smug_pkg::LVL_C6) || (level_reg == smug_pkg::LVL_C8)) ?
                        HOLD_LONG_MS : HOLD_SHORT_MS; // R15
    assign hold_done = (hold_ms_reg >= hold_limit);
    assign frames_per_page = 9'(smug_pkg::FRAMES_PER_BLOCK) * 9'(drx_reg); // R10
    assign page_start = (frame_cyc_reg == FRAME_CYC - 20'h00001) &&
                        (frame_num_reg == frames_per_page - 9'h001); // R9

    always_comb begin
        state_next = state_reg;
        level_next = level_reg;
        case (state_reg)
            smug_pkg::ST_FULL: begin
                if (cmd_ok) begin
                    level_next = cmd_level_in;
                    state_next = state_for(cmd_level_in);
                end
            end
            smug_pkg::ST_NCS: begin
                if (wake_lvl0) begin
                    level_next = smug_pkg::LVL_FULL; // R3
                    state_next = smug_pkg::ST_FULL; // R3
                end else if (page_start) begin
                    state_next = smug_pkg::ST_NCS_LISTEN; // R2
                end
            end
            smug_pkg::ST_NCS_LISTEN: begin
                if (wake_lvl0) begin
                    level_next = smug_pkg::LVL_FULL; // R3
                    state_next = smug_pkg::ST_FULL;
                end else if (tmr_reg == WIN_CYC - 20'h00001) begin
                    state_next = smug_pkg::ST_NCS; // R2
                end
            end
            smug_pkg::ST_CS_SLEEP: begin
                if (wake_cyc) begin
                    level_next = smug_pkg::LVL_FULL; // R18
                    state_next = smug_pkg::ST_FULL;
                end else if (page_start) begin
                    state_next = smug_pkg::ST_CS_WIN; // R9
                end else if (tx_pend) begin
                    state_next = smug_pkg::ST_CS_ACTIVE; // R14
                end
            end
            smug_pkg::ST_CS_WIN: begin
                if (wake_cyc) begin
                    level_next = smug_pkg::LVL_FULL; // R18
                    state_next = smug_pkg::ST_FULL;
                end else if (cmd_ok) begin
                    level_next = cmd_level_in; // R21
                    state_next = state_for(cmd_level_in); // R21
                end else if (rx_start || tx_pend || cmd_valid_in) begin
                    state_next = smug_pkg::ST_CS_ACTIVE; // R13 R14
                end else if (tmr_reg == {WIN_CYC[18:0], 1'b0} - 20'h00001) begin
                    state_next = smug_pkg::ST_CS_SLEEP; // R24
                end
            end
            smug_pkg::ST_CS_ACTIVE: begin
                if (wake_cyc) begin
                    level_next = smug_pkg::LVL_FULL; // R18
                    state_next = smug_pkg::ST_FULL;
                end else if (cmd_ok) begin
                    level_next = cmd_level_in; // R21
                    state_next = state_for(cmd_level_in); // R21
                end else if (tx_pend || cmd_valid_in) begin
                    state_next = smug_pkg::ST_CS_ACTIVE; // R14
                end else if (transfer_end_in &&
                             ((level_reg == smug_pkg::LVL_C7) || (level_reg == smug_pkg::LVL_C8))) begin
                    state_next = smug_pkg::ST_CS_SLEEP; // R5
                end else if (hold_done) begin
                    state_next = smug_pkg::ST_CS_SLEEP; // R24
                end
            end
            default: begin
                level_next = smug_pkg::LVL_FULL;
                state_next = smug_pkg::ST_FULL;
            end
        endcase
    end

    // level and sequencer state
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_reg <= smug_pkg::ST_FULL; // R23
            level_reg <= smug_pkg::LVL_FULL; // R23
        end else begin
            state_reg <= state_next;
            level_reg <= level_next;
        end
    end

    // rts edge history
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rts_n_reg <= 2'h3;
        end else begin
            rts_n_reg <= rts_n_in;
        end
    end

    // paging schedule runs free in every level, frame by frame
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            frame_cyc_reg <= 20'h00000;
            frame_num_reg <= 9'h000;
        end else if (frame_cyc_reg == FRAME_CYC - 20'h00001) begin
            frame_cyc_reg <= 20'h00000;
            // a drx change takes effect at once; a count past the new page end wraps at the frame end
            if (frame_num_reg >= frames_per_page - 9'h001) begin
                frame_num_reg <= 9'h000; // R10
            end else begin
                frame_num_reg <= frame_num_reg + 9'h001;
            end
        end else begin
            frame_cyc_reg <= frame_cyc_reg + 20'h00001;
        end
    end

    // listen and window timer, cleared on every state change
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tmr_reg <= 20'h00000;
        end else if (state_next != state_reg) begin
            tmr_reg <= 20'h00000;
        end else begin
            tmr_reg <= tmr_reg + 20'h00001; // R12
        end
    end

    // hold timer in milliseconds; restarted by each character
    assign hold_restart = (state_next == smug_pkg::ST_CS_ACTIVE) &&
                          ((state_reg != smug_pkg::ST_CS_ACTIVE) || activity);
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ms_div_reg  <= 20'h00000;
            hold_ms_reg <= 20'h00000;
        end else if (hold_restart) begin
            ms_div_reg  <= 20'h00000; // R15
            hold_ms_reg <= 20'h00000; // R15
        end else if (ms_div_reg == MS_CYC - 20'h00001) begin
            ms_div_reg <= 20'h00000;
            if (!hold_done) begin
                hold_ms_reg <= hold_ms_reg + 20'h00001; // R15
            end
        end else begin
            ms_div_reg <= ms_div_reg + 20'h00001;
        end
    end

    // cts low: full level, active hold, first half of the paging window
    assign cts_low = (state_reg == smug_pkg::ST_FULL) || (state_reg == smug_pkg::ST_CS_ACTIVE) ||
                     ((state_reg == smug_pkg::ST_CS_WIN) && (tmr_reg < WIN_CYC)); // R6 R12

    // gating outputs, one cycle behind the state
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cts_n_out      <= 2'h0;
            uart_en_out    <= 1'b1;
            host_ready_out <= 2'h0;
            power_save_out <= 1'b0;
            level_out      <= smug_pkg::LVL_FULL;
        end else begin
            cts_n_out      <= {2{~cts_low}}; // R6 R8
            uart_en_out    <= uart_open; // R1 R16
            // rts only tells that the host can take data
            host_ready_out <= ~rts_n_in & {2{uart_open}}; // R17
            // packet data suspends saving without leaving the level
            power_save_out <= ((state_reg == smug_pkg::ST_NCS) ||
                               (state_reg == smug_pkg::ST_CS_SLEEP)) && !packet_active_in; // R4 R19
            level_out      <= level_reg;
        end
    end

    // software registers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            drx_reg     <= smug_pkg::DRX_RESET;
            flow_reg    <= smug_pkg::FLOW_NONE;
            sms_ind_reg <= 1'b0;
        end else if (wr_en_in) begin
            if (addr_in == smug_pkg::OFS_DRX) begin
                if ((wr_data_in[3:0] >= smug_pkg::DRX_MIN) && (wr_data_in[3:0] <= smug_pkg::DRX_MAX) &&
                    (wr_data_in[31:4] == 28'h0000000)) begin
                    drx_reg <= wr_data_in[3:0]; // R11
                end
            end else if (addr_in == smug_pkg::OFS_FLOW) begin
                flow_reg <= wr_data_in[1:0]; // R7
            end else if (addr_in == smug_pkg::OFS_SMSIND) begin
                sms_ind_reg <= wr_data_in[0]; // R20
            end
        end
    end

    assign status.state      = state_reg;
    assign status.power_save = power_save_out;
    assign status.uart_en    = uart_en_out;
    assign status.cts_n      = cts_n_out[0];
    assign status.level      = level_reg;

    // read data valid the cycle after the strobe only
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rd_data_out <= 32'h00000000;
        end else if (!rd_en_in) begin
            rd_data_out <= 32'h00000000;
        end else if (addr_in == smug_pkg::OFS_LEVEL) begin
            rd_data_out <= {28'h0000000, level_reg};
        end else if (addr_in == smug_pkg::OFS_DRX) begin
            rd_data_out <= {28'h0000000, drx_reg};
        end else if (addr_in == smug_pkg::OFS_FLOW) begin
            rd_data_out <= {30'h00000000, flow_reg};
        end else if (addr_in == smug_pkg::OFS_SMSIND) begin
            rd_data_out <= {31'h00000000, sms_ind_reg};
        end else if (addr_in == smug_pkg::OFS_STATUS) begin
            rd_data_out <= {19'h00000, status};
        end else begin
            rd_data_out <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire
